// ===== design/wtg_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
//          of the windowed timeout guard.
// Assumes: 32-bit APB data, byte addresses, one aligned word per register.
// Notes:   Definitions only.
`ifndef WTG_REGS_SVH
`define WTG_REGS_SVH

`define WTG_ADDR_W 12
`define WTG_OFF_CTRL 12'h000
`define WTG_OFF_TIMEOUT 12'h004
`define WTG_OFF_FEED 12'h008
`define WTG_OFF_COUNT 12'h00c
`define WTG_OFF_WARN 12'h010
`define WTG_OFF_WINDOW 12'h014
`define WTG_OFF_STATUS 12'h018
`define WTG_OFF_MASK 12'h01c

// Control fields
`define WTG_CTRL_EN 0
`define WTG_CTRL_RSTEN 1
`define WTG_CTRL_WINEN 2
`define WTG_CTRL_CLKSEL 3

// Status and mask fields
`define WTG_ST_TIMEOUT 0
`define WTG_ST_WARN 1
`define WTG_ST_BADFEED 2
`define WTG_ST_WDRESET 3

// Reset values and timeout floor
`define WTG_TIMEOUT_RST 24'hffffff
`define WTG_TIMEOUT_MIN 24'h0000ff
`define WTG_WARN_RST 24'h000000
`define WTG_WINDOW_RST 24'hffffff

// Feed sequence bytes
`define WTG_FEED_FIRST 8'haa
`define WTG_FEED_SECOND 8'h55

// Prescaler and timing
`define WTG_PRESC_LAST 2'h3
`define WTG_CLK_NS 50
`define WTG_RST_PULSE_NS 200
`define WTG_RST_CYC (`WTG_RST_PULSE_NS / `WTG_CLK_NS)

`endif

// ===== design/wtg_pkg.sv
// Purpose: Types shared by the windowed timeout guard modules.
// Assumes: Constants live in wtg_regs.svh.
// Notes:   Nothing is imported; users write wtg_pkg::name.
package wtg_pkg;

  typedef logic [23:0] wtg_cnt_t;

  typedef enum logic [1:0] {
    WTG_FEED_IDLE = 2'h0,
    WTG_FEED_HALF = 2'h1
  } wtg_feed_e;

  typedef struct packed {
    logic src_prev;
    logic [1:0] presc;
    logic tick;
  } wtg_tick_s;

  typedef struct packed {
    wtg_feed_e state;
  } wtg_feed_s;

  typedef struct packed {
    logic enable;
    logic rst_en;
    logic win_en;
    logic clk_sel;
    wtg_cnt_t timeout;
    wtg_cnt_t warn;
    wtg_cnt_t window;
    wtg_cnt_t count;
    logic [3:0] status;
    logic [3:0] mask;
    logic [2:0] rst_cnt;
    logic chip_rst;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wtg_main_s;

endpackage : wtg_pkg

// ===== design/wtg_tick_gen.sv
// Purpose: Count clock source select and divide-by-four prescaler.
// Assumes: Oscillator inputs are synchronous levels slower than clk/2.
// Notes:   One tick per four rising edges of the selected source.
`timescale 1ns/1ps
`include "wtg_regs.svh"
module wtg_tick_gen (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic sel_rc_in,
  input wire logic guard_dedicated_oscillator_in,
  input wire logic internal_rc_oscillator_in,
  output logic tick_out
);
  wtg_pkg::wtg_tick_s q_r;
  wtg_pkg::wtg_tick_s q_nxt;
  logic src;

  // R9 R10 source choice
  assign src = sel_rc_in ? internal_rc_oscillator_in
                         : guard_dedicated_oscillator_in;

  always_comb begin
    q_nxt = q_r;
    q_nxt.src_prev = src;
    q_nxt.tick = 1'b0;
    // R7 divide by four
    if (src && !q_r.src_prev) begin
      q_nxt.presc = q_r.presc + 2'h1;
      q_nxt.tick = (q_r.presc == `WTG_PRESC_LAST);
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign tick_out = q_r.tick;

  a_tick_spacing: assert property (@(posedge clk_sys_in) // R7
    disable iff (!resetn_in) tick_out |=> !tick_out [*3])
    else $error("prescaler ticks closer than four source edges");

endmodule : wtg_tick_gen

// ===== design/wtg_feed_check.sv
// Purpose: Checks the two-write feed sequence on the feed register.
// Assumes: Write strobes are one-cycle pulses at the APB access edge.
// Notes:   Any other register write between the two bytes breaks it.
`timescale 1ns/1ps
`include "wtg_regs.svh"
module wtg_feed_check (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic wr_feed_in,
  input wire logic wr_other_in,
  input wire logic [7:0] wdata_in,
  output logic feed_ok_out,
  output logic feed_bad_out
);
  wtg_pkg::wtg_feed_s q_r;
  wtg_pkg::wtg_feed_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    feed_ok_out = 1'b0;
    feed_bad_out = 1'b0;
    // R11 fixed sequence
    unique case (q_r.state)
      wtg_pkg::WTG_FEED_IDLE: begin
        if (wr_feed_in) begin
          if (wdata_in == `WTG_FEED_FIRST) begin
            q_nxt.state = wtg_pkg::WTG_FEED_HALF;
          end else begin
            feed_bad_out = 1'b1;
          end
        end
      end
      wtg_pkg::WTG_FEED_HALF: begin
        if (wr_feed_in || wr_other_in) begin
          q_nxt.state = wtg_pkg::WTG_FEED_IDLE;
          feed_ok_out = wr_feed_in && (wdata_in == `WTG_FEED_SECOND);
          feed_bad_out = !feed_ok_out;
        end
      end
      default: begin
        q_nxt.state = wtg_pkg::WTG_FEED_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  a_feed_order: assert property (@(posedge clk_sys_in) // R11
    disable iff (!resetn_in)
    feed_ok_out |-> q_r.state == wtg_pkg::WTG_FEED_HALF && wr_feed_in)
    else $error("feed accepted without first byte");

endmodule : wtg_feed_check

// ===== design/wtg_guard.sv
// Purpose: Windowed timeout guard with APB registers and interrupt.
// Assumes: Oscillator inputs synchronous to clk_sys_in, 20 MHz system clock.
// Notes:   Faults end in a chip reset pulse or an interrupt, then disable.
`timescale 1ns/1ps
`include "wtg_regs.svh"
// Function
// R1: Counter expiry without feed causes an internal chip reset.
// R2: With window on, a feed is valid only between minimum and maximum.
// R3: A warning interrupt is raised at a programmable count.
// R4: Enable is set by software only; hardware reset or a fault clears it.
// R5: A bad feed causes a reset, or an interrupt when reset is off.
// R6: A status flag records that the guard caused a reset.
// R7: The timeout counter is 24 bits, fed through a divide-by-four prescaler.
// R8: Timeout spans 256 to 2^24 steps of four count clocks.
// R9: The count clock comes from the dedicated guard oscillator.
// R10: The internal RC oscillator may be chosen as count clock instead.
// R11: A feed is a fixed pair of consecutive writes to the feed register.
// R12: A valid feed reloads the counter from the timeout value.
module wtg_guard (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic guard_dedicated_oscillator_in,
  input wire logic internal_rc_oscillator_in,
  output logic irq_out,
  output logic chip_reset_out
);
  wtg_pkg::wtg_main_s q_r;
  wtg_pkg::wtg_main_s q_nxt;
  logic setup;
  logic wr;
  logic wr_feed;
  logic wr_other;
  logic tick;
  logic feed_ok;
  logic feed_bad;
  logic too_early;
  logic good_feed;
  logic bad_feed;
  logic expire;
  logic warn_hit;
  logic fault;

  function automatic logic wtg_mapped(input logic [11:0] a);
    unique case (a)
      `WTG_OFF_CTRL, `WTG_OFF_TIMEOUT, `WTG_OFF_FEED, `WTG_OFF_COUNT,
      `WTG_OFF_WARN, `WTG_OFF_WINDOW, `WTG_OFF_STATUS,
      `WTG_OFF_MASK: begin
        wtg_mapped = 1'b1;
      end
      default: begin
        wtg_mapped = 1'b0;
      end
    endcase
  endfunction : wtg_mapped

  function automatic logic [31:0] wtg_read(input logic [11:0] a,
                                           input wtg_pkg::wtg_main_s s);
    unique case (a)
      `WTG_OFF_CTRL: begin
        wtg_read = {28'h0000000, s.clk_sel, s.win_en, s.rst_en, s.enable};
      end
      `WTG_OFF_TIMEOUT: begin
        wtg_read = {8'h00, s.timeout};
      end
      `WTG_OFF_COUNT: begin
        wtg_read = {8'h00, s.count};
      end
      `WTG_OFF_WARN: begin
        wtg_read = {8'h00, s.warn};
      end
      `WTG_OFF_WINDOW: begin
        wtg_read = {8'h00, s.window};
      end
      `WTG_OFF_STATUS: begin
        wtg_read = {28'h0000000, s.status};
      end
      `WTG_OFF_MASK: begin
        wtg_read = {28'h0000000, s.mask};
      end
      default: begin
        wtg_read = 32'h00000000;
      end
    endcase
  endfunction : wtg_read

  // Ready is registered, so each transfer has one wait-free access cycle
  assign setup = psel_in && !penable_in && !q_r.pready;
  assign wr = psel_in && penable_in && q_r.pready && pwrite_in &&
              !q_r.pslverr;
  assign wr_feed = wr && (paddr_in == `WTG_OFF_FEED);
  assign wr_other = wr && (paddr_in != `WTG_OFF_FEED);

  wtg_tick_gen u_tick (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .sel_rc_in(q_r.clk_sel),
    .guard_dedicated_oscillator_in(guard_dedicated_oscillator_in),
    .internal_rc_oscillator_in(internal_rc_oscillator_in),
    .tick_out(tick)
  );

  wtg_feed_check u_feed (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .wr_feed_in(wr_feed),
    .wr_other_in(wr_other),
    .wdata_in(pwdata_in[7:0]),
    .feed_ok_out(feed_ok),
    .feed_bad_out(feed_bad)
  );

  // R2 window check
  assign too_early = q_r.win_en && (q_r.count > q_r.window);
  assign good_feed = feed_ok && !too_early;
  // R5 bad feed only counts while running
  assign bad_feed = q_r.enable && (feed_bad || (feed_ok && too_early));
  // R1 expiry
  assign expire = q_r.enable && tick && (q_r.count == 24'h000000);
  // R3 warning point
  assign warn_hit = q_r.enable && tick && (q_r.count == q_r.warn);
  assign fault = expire || bad_feed;

  always_comb begin
    q_nxt = q_r;
    q_nxt.pready = setup;
    q_nxt.pslverr = setup && !wtg_mapped(paddr_in);
    if (setup && !pwrite_in) begin
      q_nxt.prdata = wtg_read(paddr_in, q_r);
    end
    if (wr) begin
      unique case (paddr_in)
        `WTG_OFF_CTRL: begin
          // R4 enable and reset mode cannot be cleared by software
          q_nxt.enable = q_r.enable || pwdata_in[`WTG_CTRL_EN];
          q_nxt.rst_en = q_r.rst_en || pwdata_in[`WTG_CTRL_RSTEN];
          q_nxt.win_en = pwdata_in[`WTG_CTRL_WINEN];
          // R9 R10 source locked while running to avoid a false edge
          if (!q_r.enable) begin
            q_nxt.clk_sel = pwdata_in[`WTG_CTRL_CLKSEL];
          end
          if (!q_r.enable && pwdata_in[`WTG_CTRL_EN]) begin
            q_nxt.count = q_r.timeout;
          end
        end
        `WTG_OFF_TIMEOUT: begin
          // R8 floor of 256 steps
          if (pwdata_in[23:0] < `WTG_TIMEOUT_MIN) begin
            q_nxt.timeout = `WTG_TIMEOUT_MIN;
          end else begin
            q_nxt.timeout = pwdata_in[23:0];
          end
        end
        `WTG_OFF_WARN: begin
          q_nxt.warn = pwdata_in[23:0];
        end
        `WTG_OFF_WINDOW: begin
          q_nxt.window = pwdata_in[23:0];
        end
        `WTG_OFF_MASK: begin
          q_nxt.mask = pwdata_in[3:0];
        end
        default: begin
        end
      endcase
    end
    // R7 R12 count down, reload on feed
    if (q_r.enable) begin
      if (good_feed) begin
        q_nxt.count = q_r.timeout;
      end else if (tick && q_r.count != 24'h000000) begin
        q_nxt.count = q_r.count - 24'h000001;
      end
    end
    // Set wins over write-one-to-clear
    q_nxt.status = q_r.status;
    if (wr && paddr_in == `WTG_OFF_STATUS) begin
      q_nxt.status = q_r.status & ~pwdata_in[3:0];
    end
    q_nxt.status[`WTG_ST_WARN] = q_nxt.status[`WTG_ST_WARN] || warn_hit;
    q_nxt.status[`WTG_ST_TIMEOUT] = q_nxt.status[`WTG_ST_TIMEOUT] || expire;
    q_nxt.status[`WTG_ST_BADFEED] = q_nxt.status[`WTG_ST_BADFEED] ||
                                    bad_feed;
    if (fault) begin
      // R4 fault disables the guard
      q_nxt.enable = 1'b0;
      q_nxt.rst_en = 1'b0;
      q_nxt.count = q_r.timeout;
    end
    // Pulse keeps counting down even if an interrupt-mode fault lands in it
    if (fault && q_r.rst_en) begin
      // R1 R5 R6 chip reset and flag
      q_nxt.rst_cnt = 3'(`WTG_RST_CYC);
      q_nxt.status[`WTG_ST_WDRESET] = 1'b1;
    end else if (q_r.rst_cnt != 3'h0) begin
      q_nxt.rst_cnt = q_r.rst_cnt - 3'h1;
    end
    q_nxt.chip_rst = (q_nxt.rst_cnt != 3'h0);
    q_nxt.irq = |(q_nxt.status & q_nxt.mask);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_r <= '0;
      q_r.timeout <= `WTG_TIMEOUT_RST;
      q_r.warn <= `WTG_WARN_RST;
      q_r.window <= `WTG_WINDOW_RST;
      q_r.count <= `WTG_TIMEOUT_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata_out = q_r.prdata;
  assign pready_out = q_r.pready;
  assign pslverr_out = q_r.pslverr;
  assign irq_out = q_r.irq;
  assign chip_reset_out = q_r.chip_rst;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_expire_reset: assert property ( // R1
    expire && q_r.rst_en |=> chip_reset_out [*4] ##1 !chip_reset_out)
    else $error("expiry did not give a four cycle chip reset");

  a_window_early: assert property ( // R2
    q_r.enable && feed_ok && too_early |=>
      !q_r.enable && q_r.status[`WTG_ST_BADFEED])
    else $error("early feed was not treated as fault");

  a_warn_flag: assert property ( // R3
    warn_hit |=> q_r.status[`WTG_ST_WARN] ##1 irq_out || !q_r.mask[1])
    else $error("warning point did not raise status");

  a_enable_sticky: assert property ( // R4
    q_r.enable && !fault |=> q_r.enable)
    else $error("guard disabled without fault or reset");

  a_bad_feed_irq: assert property ( // R5
    bad_feed && !q_r.rst_en |=> !chip_reset_out &&
      q_r.status[`WTG_ST_BADFEED] && !q_r.enable)
    else $error("bad feed in interrupt mode mishandled");

  a_reset_flag: assert property ( // R6
    $rose(chip_reset_out) |-> q_r.status[`WTG_ST_WDRESET])
    else $error("chip reset without reset flag");

  a_count_step: assert property ( // R7
    q_r.enable && tick && q_r.count != 24'h000000 && !good_feed &&
      !fault |=> q_r.count == $past(q_r.count) - 24'h000001)
    else $error("counter did not step down by one");

  a_timeout_floor: assert property ( // R8
    q_r.timeout >= `WTG_TIMEOUT_MIN)
    else $error("timeout below 256 steps");

  a_feed_reload: assert property ( // R12
    q_r.enable && good_feed && !fault |=> q_r.count == $past(q_r.timeout))
    else $error("valid feed did not reload counter");

  a_bad_feed_reset: assert property ( // R5
    bad_feed && q_r.rst_en |=> chip_reset_out &&
      q_r.status[`WTG_ST_WDRESET] && !q_r.enable)
    else $error("bad feed in reset mode gave no chip reset");

  a_flag_cause: assert property ( // R6
    !(fault && q_r.rst_en) |=> !$rose(q_r.status[`WTG_ST_WDRESET]))
    else $error("reset flag set without a guard reset");

  a_source_lock: assert property ( // R9 R10
    q_r.enable |=> q_r.clk_sel == $past(q_r.clk_sel))
    else $error("count clock source changed while running");

  a_expire_flag: assert property ( // R1
    expire |=> q_r.status[`WTG_ST_TIMEOUT] && !q_r.enable &&
      q_r.count == $past(q_r.timeout))
    else $error("expiry did not stop and flag the guard");

  a_count_idle: assert property ( // R7
    !q_r.enable && !wr |=> q_r.count == $past(q_r.count))
    else $error("counter moved while the guard was off");

  a_window_ok: assert property ( // R2
    q_r.enable && feed_ok && !too_early && !expire |=>
      q_r.enable && q_r.count == $past(q_r.timeout))
    else $error("feed inside the window was refused");

  c_expire_reset: cover property (expire && q_r.rst_en);
  c_good_feed: cover property (q_r.enable && good_feed);
  c_warn_irq: cover property (warn_hit ##1 irq_out);
  c_bad_feed_irq: cover property (bad_feed && !q_r.rst_en);
  c_window_feed: cover property (q_r.win_en && q_r.enable && good_feed);

endmodule : wtg_guard

// ===== sim/tb_windowed_watchdog_timer.sv
// Purpose: Self-checking bench for the windowed timeout guard over APB.
// Assumes: Bench drives both oscillators, 4 clocks per period when running.
// Notes:   Stopped oscillators hold level so COUNT reads are exact.
`timescale 1ns/1ps
`include "wtg_regs.svh"
module tb_windowed_watchdog_timer;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic osc_ded = 1'b0;
  logic osc_rc = 1'b0;
  logic ded_run = 1'b0;
  logic rc_run = 1'b0;
  logic tgl = 1'b0;
  logic irq_out;
  logic chip_reset_out;
  logic [31:0] q;
  logic e;
  int fails = 0;
  int checks_done = 0;
  int n;

  wtg_guard dut (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .guard_dedicated_oscillator_in(osc_ded),
    .internal_rc_oscillator_in(osc_rc),
    .irq_out(irq_out),
    .chip_reset_out(chip_reset_out)
  );

  always #25 clk_sys_in = ~clk_sys_in;

  // Slow enough for the sampled edge detector
  always @(posedge clk_sys_in) begin
    tgl <= ~tgl;
    if (tgl && ded_run) osc_ded <= ~osc_ded;
    if (tgl && rc_run) osc_rc <= ~osc_rc;
  end

  task automatic finish_test;
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Outputs read right after the edge still show pre-edge values
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (pready_out !== 1'b1 && k < 16);
    check("pready", 32'h1, {31'h0, pready_out});
    q = prdata_out;
    e = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask : rdc

  task automatic feed(input logic [7:0] second);
    wr(`WTG_OFF_FEED, {24'h0, `WTG_FEED_FIRST});
    wr(`WTG_OFF_FEED, {24'h0, second});
  endtask : feed

  initial begin
    repeat (30000) @(posedge clk_sys_in);
    fails++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rdc("ctrl", `WTG_OFF_CTRL, 32'h0);
    rdc("timeout", `WTG_OFF_TIMEOUT, 32'h00ffffff);
    rdc("count", `WTG_OFF_COUNT, 32'h00ffffff);
    rdc("window", `WTG_OFF_WINDOW, 32'h00ffffff);
    rdc("status", `WTG_OFF_STATUS, 32'h0);
    rdc("unmapped", 12'h020, 32'h0);
    check("pslverr", 32'h1, {31'h0, e});
    wr(`WTG_OFF_TIMEOUT, 32'h01234567);
    rdc("timeout wide", `WTG_OFF_TIMEOUT, 32'h00234567);
    wr(`WTG_OFF_TIMEOUT, 32'h10);
    rdc("timeout min", `WTG_OFF_TIMEOUT, 32'h000000ff);
    wr(`WTG_OFF_WARN, 32'h80);
    wr(`WTG_OFF_CTRL, 32'h3);
    wr(`WTG_OFF_CTRL, 32'h0);
    rdc("ctrl locked", `WTG_OFF_CTRL, 32'h3);
    rdc("count load", `WTG_OFF_COUNT, 32'h000000ff);
    ded_run <= 1'b1;
    n = 0;
    while (chip_reset_out !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_in);
      n++;
    end
    // Expiry after (0xff+1)*4 edges of 4 clocks each
    check("expiry time", 32'h1, {31'h0, n >= 4090 && n <= 4110});
    n = 0;
    while (chip_reset_out === 1'b1 && n < 10) begin
      @(posedge clk_sys_in);
      n++;
    end
    check("reset pulse", 32'h4, n);
    ded_run <= 1'b0;
    rdc("status expiry", `WTG_OFF_STATUS, 32'hb);
    rdc("ctrl cleared", `WTG_OFF_CTRL, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq_out});
    wr(`WTG_OFF_STATUS, 32'hf);
    rdc("status w1c", `WTG_OFF_STATUS, 32'h0);
    wr(`WTG_OFF_MASK, 32'h7);
    wr(`WTG_OFF_CTRL, 32'h8);
    wr(`WTG_OFF_CTRL, 32'h9);
    rc_run <= 1'b1;
    repeat (200) @(posedge clk_sys_in);
    rc_run <= 1'b0;
    apb(1'b0, `WTG_OFF_COUNT, 32'h0);
    check("rc counts", 32'h1, {31'h0, q[23:0] < 24'hff});
    feed(`WTG_FEED_SECOND);
    rdc("count fed", `WTG_OFF_COUNT, 32'h000000ff);
    feed(8'h12);
    rdc("status bad", `WTG_OFF_STATUS, 32'h4);
    check("irq bad", 32'h1, {31'h0, irq_out});
    check("no reset", 32'h0, {31'h0, chip_reset_out});
    rdc("ctrl off", `WTG_OFF_CTRL, 32'h8);
    wr(`WTG_OFF_STATUS, 32'h4);
    repeat (2) @(posedge clk_sys_in);
    check("irq clear", 32'h0, {31'h0, irq_out});
    wr(`WTG_OFF_CTRL, 32'h9);
    wr(`WTG_OFF_FEED, {24'h0, `WTG_FEED_FIRST});
    wr(`WTG_OFF_MASK, 32'h3);
    rdc("status other", `WTG_OFF_STATUS, 32'h4);
    check("irq mask", 32'h0, {31'h0, irq_out});
    wr(`WTG_OFF_MASK, 32'h4);
    repeat (2) @(posedge clk_sys_in);
    check("irq unmask", 32'h1, {31'h0, irq_out});
    wr(`WTG_OFF_STATUS, 32'hf);
    wr(`WTG_OFF_WINDOW, 32'h80);
    wr(`WTG_OFF_CTRL, 32'hd);
    feed(`WTG_FEED_SECOND);
    rdc("status early", `WTG_OFF_STATUS, 32'h4);
    wr(`WTG_OFF_STATUS, 32'hf);
    wr(`WTG_OFF_CTRL, 32'hd);
    rc_run <= 1'b1;
    repeat (2200) @(posedge clk_sys_in);
    rc_run <= 1'b0;
    feed(`WTG_FEED_SECOND);
    rdc("status window", `WTG_OFF_STATUS, 32'h2);
    rdc("count window", `WTG_OFF_COUNT, 32'h000000ff);
    // Reset mode set on a running guard, then a bad second byte
    wr(`WTG_OFF_STATUS, 32'hf);
    wr(`WTG_OFF_CTRL, 32'hf);
    feed(8'h12);
    @(posedge clk_sys_in);
    check("reset bad", 32'h1, {31'h0, chip_reset_out});
    rdc("status bad reset", `WTG_OFF_STATUS, 32'hc);
    finish_test();
  end
endmodule : tb_windowed_watchdog_timer
